/* monitor_adc_consts.svh */
`ifndef MONITOR_ADC_CONSTS_SVH
`define MONITOR_ADC_CONSTS_SVH

// Command codes carried in the upper nibble of the command word
`define CMD_MANUAL 4'h0
`define CMD_RD_ALARM 4'h1
`define CMD_RD_DATA 4'h2
`define CMD_RD_ALL 4'h3
`define CMD_RD_CHCFG 4'h4
`define CMD_RD_GLOBAL 4'h5
`define CMD_RESET 4'h7
`define CMD_CLR_ONE 4'h8
`define CMD_CLR_ALL 4'h9
`define CMD_WR_DATA 4'ha
`define CMD_WR_ALL 4'hb
`define CMD_WR_CHCFG 4'hc
`define CMD_WR_GLOBAL 4'hd

// Channel addressing: 0 temperature, 1 supply, 2..9 analog inputs
`define CHAN_COUNT 4'ha
`define CHAN_FIRST_ANALOG 4'h2

// Byte positions inside data phases
`define BYTE_FIRST_LO 5'h01
`define BYTE_SECOND_LO 5'h03
`define BYTE_LAST 5'h04
`define DATA_BYTES 5'h14
`define BIT_LAST 3'h7

// Reset values
`define CHAN_ENABLE_RESET 12'hfff
`define INPUT_CFG_RESET 12'h000
`define SETUP_RESET 8'h00
`define LINK_IDLE 3'h1

// Field positions
`define SETUP_SCAN_BIT 2
`define DATA_PAD_BITS 6

`endif

/* monitor_adc_pkg.sv */
package monitor_adc_pkg;

  // Serial link sequencing states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD = 5'b00010,
    ST_READ = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_SKIP = 5'b10000
  } link_state_t;

endpackage

/* link_sync.sv */
`include "monitor_adc_consts.svh"

module link_sync (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw pins {din, sclk, cs_n}
  input wire logic [2:0] pin_in,
  // Synchronised level and its previous value
  output logic [2:0] level,
  output logic [2:0] level_prev
);

  logic [2:0] meta;
  logic [2:0] next_meta;
  logic [2:0] next_level;
  logic [2:0] next_level_prev;

  // Two-stage chain plus one delay stage for edge detection
  always_comb begin
    next_meta = ce ? pin_in : meta;
    next_level = ce ? meta : level;
    next_level_prev = ce ? level : level_prev;
  end

  // Idle state holds chip select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= `LINK_IDLE;
      level <= `LINK_IDLE;
      level_prev <= `LINK_IDLE;
    end else begin
      meta <= next_meta;
      level <= next_level;
      level_prev <= next_level_prev;
    end
  end

endmodule

/* monitor_adc_command_decoder.sv */
`include "monitor_adc_consts.svh"

module monitor_adc_command_decoder (
  // Clock, reset and clock enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // Conversion engine
  input wire logic result_valid,
  input wire logic [3:0] result_channel,
  input wire logic [9:0] result_data,
  output logic conv_start,
  output logic [3:0] conv_channel,
  // Alarm and fault counter logic
  input wire logic [23:0] alarm_status,
  output logic alarm_clear,
  output logic [3:0] alarm_clear_channel,
  output logic alarm_clear_all,
  // Configuration seen by the scan logic
  output logic [11:0] channel_enable,
  output logic [11:0] input_pair_configuration,
  output logic [7:0] setup,
  output logic [11:0] scan_enable,
  output logic shutdown
);

  // Address lies in the documented channel range
  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = a < `CHAN_COUNT;
  endfunction

  // Pair code of an analog address has its differential bit set
  function automatic logic is_diff(input logic [11:0] icfg,
                                   input logic [3:0] a);
    logic [3:0] off;
    off = a - `CHAN_FIRST_ANALOG;
    if (a < `CHAN_FIRST_ANALOG || !addr_ok(a)) begin
      is_diff = 1'b0;
    end else begin
      case (off[2:1])
        2'h0: is_diff = icfg[11];
        2'h1: is_diff = icfg[8];
        2'h2: is_diff = icfg[5];
        default: is_diff = icfg[2];
      endcase
    end
  endfunction

  // Ten-bit result left aligned in a two-byte word
  function automatic logic [15:0] pad(input logic [9:0] d);
    pad = {d, `DATA_PAD_BITS'h0};
  endfunction

  // Ten-bit value taken from a left-aligned two-byte word
  function automatic logic [9:0] unpad(input logic [15:0] w);
    unpad = w[15:6];
  endfunction

  logic [2:0] lvl;
  logic [2:0] lvl_prev;
  logic cs_hi;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;

  monitor_adc_pkg::link_state_t state, next_state;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [4:0] byte_cnt, next_byte_cnt;
  logic [7:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  logic [7:0] cmd, next_cmd;
  logic [7:0] hold, next_hold;
  logic next_dout;
  logic conv_pending, next_conv_pending;
  logic next_conv_start;
  logic [3:0] next_conv_channel;
  logic next_alarm_clear;
  logic [3:0] next_alarm_clear_channel;
  logic next_alarm_clear_all;
  logic [11:0] next_channel_enable;
  logic [11:0] next_input_cfg;
  logic [11:0] input_cfg_q;
  logic [7:0] next_setup;
  logic next_shutdown;
  logic [9:0] data_mem [10];
  logic [9:0] next_data_mem [10];
  logic [15:0] upper [10];
  logic [15:0] next_upper [10];
  logic [15:0] lower [10];
  logic [15:0] next_lower [10];
  logic [7:0] ch_cfg [10];
  logic [7:0] next_ch_cfg [10];
  logic [159:0] rd_vec;
  logic [7:0] rd_byte;
  logic [7:0] in_byte;
  logic [15:0] in_word;
  logic [3:0] ch;

  // Pin synchroniser
  link_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin_in({din, sclk, cs_n}),
    .level(lvl),
    .level_prev(lvl_prev)
  );

  // Link events from synchronised pins
  assign cs_hi = lvl[0];
  assign cs_rise = lvl[0] & ~lvl_prev[0];
  assign sclk_rise = lvl[1] & ~lvl_prev[1];
  assign sclk_fall = ~lvl[1] & lvl_prev[1];
  assign din_s = lvl[2];
  assign dout_oe = ~cs_hi;
  assign input_pair_configuration = input_cfg_q;
  assign ch = cmd[3:0];
  assign in_byte = {shift_in[6:0], din_s};
  assign in_word = {hold, in_byte};

  // Scan enables with reserved and ignored odd bits masked
  always_comb begin
    scan_enable = channel_enable & 12'hffc;
    for (int k = 1; k < 8; k += 2) begin
      if (is_diff(input_cfg_q, 4'(k + 2))) begin
        scan_enable[9 - k] = 1'b0;
      end
    end
  end

  // Read image, left aligned, selected by command
  always_comb begin
    rd_vec = '0;
    case (cmd[7:4])
      `CMD_RD_ALARM: rd_vec[159:136] = alarm_status;
      `CMD_RD_DATA: begin
        if (addr_ok(ch)) begin
          rd_vec[159:144] = pad(data_mem[ch]);
        end
      end
      `CMD_RD_ALL: begin
        for (int i = 0; i < 10; i++) begin
          rd_vec[159 - 16 * i -: 16] = pad(data_mem[i]);
        end
      end
      `CMD_RD_CHCFG: begin
        if (addr_ok(ch)) begin
          rd_vec[159:120] = {upper[ch], lower[ch], ch_cfg[ch]};
        end
      end
      `CMD_RD_GLOBAL: begin
        rd_vec[159:120] = {4'h0, channel_enable, 4'h0, input_cfg_q,
                           setup};
      end
      default: rd_vec = '0;
    endcase
    if (byte_cnt < `DATA_BYTES) begin
      rd_byte = rd_vec[8'(8'd159 - {byte_cnt, 3'h0}) -: 8];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // Command sequencing and register update
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_cmd = cmd;
    next_hold = hold;
    next_dout = dout;
    next_conv_pending = conv_pending;
    next_conv_start = 1'b0;
    next_conv_channel = conv_channel;
    next_alarm_clear = 1'b0;
    next_alarm_clear_channel = alarm_clear_channel;
    next_alarm_clear_all = 1'b0;
    next_channel_enable = channel_enable;
    next_input_cfg = input_cfg_q;
    next_setup = setup;
    next_shutdown = shutdown;
    next_data_mem = data_mem;
    next_upper = upper;
    next_lower = lower;
    next_ch_cfg = ch_cfg;
    if (result_valid && addr_ok(result_channel)) begin
      next_data_mem[result_channel] = result_data;
    end
    if (cs_hi) begin
      next_state = monitor_adc_pkg::ST_IDLE;
      next_bit_cnt = 3'h0;
      next_byte_cnt = 5'h00;
      next_dout = 1'b0;
      if (cs_rise && conv_pending) begin
        next_conv_pending = 1'b0;
        next_conv_start = 1'b1;
      end
    end else begin
      case (state)
        monitor_adc_pkg::ST_IDLE: begin
          next_state = monitor_adc_pkg::ST_CMD;
          next_conv_pending = 1'b0;
        end
        monitor_adc_pkg::ST_CMD: begin
          if (sclk_rise) begin
            next_shift_in = in_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BIT_LAST) begin
              next_cmd = in_byte;
              next_state = monitor_adc_pkg::ST_SKIP;
              case (in_byte[7:4])
                `CMD_MANUAL: begin
                  if (!setup[`SETUP_SCAN_BIT] &&
                      addr_ok(in_byte[3:0]) &&
                      !(in_byte[0] && is_diff(input_cfg_q,
                                              in_byte[3:0]))) begin
                    next_conv_pending = 1'b1;
                    next_conv_channel = in_byte[3:0];
                  end
                end
                `CMD_RD_ALARM, `CMD_RD_DATA, `CMD_RD_ALL, `CMD_RD_CHCFG,
                `CMD_RD_GLOBAL: next_state = monitor_adc_pkg::ST_READ;
                `CMD_RESET: begin
                  next_channel_enable = `CHAN_ENABLE_RESET;
                  next_input_cfg = `INPUT_CFG_RESET;
                  next_setup = `SETUP_RESET;
                  next_shutdown = 1'b1;
                  next_alarm_clear_all = 1'b1;
                  next_data_mem = '{default: '0};
                  next_upper = '{default: '0};
                  next_lower = '{default: '0};
                  next_ch_cfg = '{default: '0};
                end
                `CMD_CLR_ONE: begin
                  if (addr_ok(in_byte[3:0])) begin
                    next_alarm_clear = 1'b1;
                    next_alarm_clear_channel = in_byte[3:0];
                  end
                end
                `CMD_CLR_ALL: next_alarm_clear_all = 1'b1;
                `CMD_WR_DATA, `CMD_WR_ALL, `CMD_WR_CHCFG,
                `CMD_WR_GLOBAL: next_state = monitor_adc_pkg::ST_WRITE;
                default: next_state = monitor_adc_pkg::ST_SKIP;
              endcase
            end
          end
        end
        monitor_adc_pkg::ST_READ: begin
          if (sclk_fall) begin
            if (bit_cnt == 3'h0) begin
              next_dout = rd_byte[7];
              next_shift_out = {rd_byte[6:0], 1'b0};
            end else begin
              next_dout = shift_out[7];
              next_shift_out = {shift_out[6:0], 1'b0};
            end
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BIT_LAST && byte_cnt < `DATA_BYTES) begin
              next_byte_cnt = byte_cnt + 5'h01;
            end
          end
        end
        monitor_adc_pkg::ST_WRITE: begin
          if (sclk_rise) begin
            next_shift_in = in_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `BIT_LAST && byte_cnt < `DATA_BYTES) begin
              next_hold = in_byte;
              next_byte_cnt = byte_cnt + 5'h01;
              case (cmd[7:4])
                `CMD_WR_DATA: begin
                  if (byte_cnt == `BYTE_FIRST_LO && addr_ok(ch)) begin
                    next_data_mem[ch] = unpad(in_word);
                  end
                end
                `CMD_WR_ALL: begin
                  if (byte_cnt[0]) begin
                    next_data_mem[byte_cnt[4:1]] = unpad(in_word);
                  end
                end
                `CMD_WR_CHCFG: begin
                  if (addr_ok(ch)) begin
                    if (byte_cnt == `BYTE_FIRST_LO) begin
                      next_upper[ch] = in_word;
                    end
                    if (byte_cnt == `BYTE_SECOND_LO) begin
                      next_lower[ch] = in_word;
                    end
                    if (byte_cnt == `BYTE_LAST) begin
                      next_ch_cfg[ch] = in_byte;
                    end
                    if (byte_cnt == `BYTE_FIRST_LO ||
                        byte_cnt == `BYTE_SECOND_LO ||
                        byte_cnt == `BYTE_LAST) begin
                      next_alarm_clear = 1'b1;
                      next_alarm_clear_channel = ch;
                    end
                  end
                end
                `CMD_WR_GLOBAL: begin
                  if (byte_cnt == `BYTE_FIRST_LO) begin
                    next_channel_enable = in_word[11:0];
                  end
                  if (byte_cnt == `BYTE_SECOND_LO) begin
                    next_input_cfg = in_word[11:0];
                  end
                  if (byte_cnt == `BYTE_LAST) begin
                    next_setup = in_byte;
                    next_shutdown = 1'b0;
                  end
                end
                default: next_hold = in_byte;
              endcase
            end
          end
        end
        monitor_adc_pkg::ST_SKIP: next_state = monitor_adc_pkg::ST_SKIP;
        default: next_state = monitor_adc_pkg::ST_IDLE;
      endcase
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= monitor_adc_pkg::ST_IDLE;
      bit_cnt <= 3'h0;
      byte_cnt <= 5'h00;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      cmd <= 8'h00;
      hold <= 8'h00;
      dout <= 1'b0;
      conv_pending <= 1'b0;
      conv_start <= 1'b0;
      conv_channel <= 4'h0;
      alarm_clear <= 1'b0;
      alarm_clear_channel <= 4'h0;
      alarm_clear_all <= 1'b0;
      channel_enable <= `CHAN_ENABLE_RESET;
      input_cfg_q <= `INPUT_CFG_RESET;
      setup <= `SETUP_RESET;
      shutdown <= 1'b1;
      data_mem <= '{default: '0};
      upper <= '{default: '0};
      lower <= '{default: '0};
      ch_cfg <= '{default: '0};
    end else if (ce) begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      cmd <= next_cmd;
      hold <= next_hold;
      dout <= next_dout;
      conv_pending <= next_conv_pending;
      conv_start <= next_conv_start;
      conv_channel <= next_conv_channel;
      alarm_clear <= next_alarm_clear;
      alarm_clear_channel <= next_alarm_clear_channel;
      alarm_clear_all <= next_alarm_clear_all;
      channel_enable <= next_channel_enable;
      input_cfg_q <= next_input_cfg;
      setup <= next_setup;
      shutdown <= next_shutdown;
      data_mem <= next_data_mem;
      upper <= next_upper;
      lower <= next_lower;
      ch_cfg <= next_ch_cfg;
    end
  end

  // Checks on the sequencing above
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_release;
    ce && cs_rise && conv_pending;
  endsequence

  sequence s_reset_cmd;
    ce && state == monitor_adc_pkg::ST_CMD && sclk_rise && !cs_hi &&
    bit_cnt == `BIT_LAST && in_byte[7:4] == `CMD_RESET;
  endsequence

  a_conv_on_release: assert property (s_release |=> conv_start)
    else $error("conversion did not start on select release");
  a_conv_scan_off: assert property (conv_start |-> !setup[2])
    else $error("conversion started in scan mode");
  a_conv_even_diff: assert property (conv_start |->
    !(conv_channel[0] && is_diff(input_cfg_q, conv_channel)))
    else $error("conversion started on odd differential input");
  a_reset_defaults: assert property (s_reset_cmd |=> shutdown &&
    channel_enable == 12'hfff && input_cfg_q == 12'h000 && setup == 8'h00)
    else $error("reset command left a register changed");
  a_clear_addr_ok: assert property (alarm_clear |->
    alarm_clear_channel < 4'ha)
    else $error("alarm clear on reserved channel");
  a_cs_resets: assert property (ce && cs_hi |=>
    state == monitor_adc_pkg::ST_IDLE ##1 !dout)
    else $error("serial interface not reset by high select");
  a_dout_on_fall: assert property ($changed(dout) && !$past(cs_hi) |->
    $past(sclk_fall))
    else $error("data output changed away from a falling edge");
  a_odd_masked: assert property (input_cfg_q[11] |->
    !scan_enable[8] && scan_enable[1:0] == 2'h0)
    else $error("ignored enable bit reached the scan logic");

endmodule

/* spi_host_model.sv */
module spi_host_model (
  // Clock
  input wire logic clk,
  // Serial link driven by the host
  output logic cs_n,
  output logic sclk,
  output logic din,
  // Serial data from the device
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx_buf [0:20];
  logic [7:0] rx_buf [0:20];

  // Deselected, clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end

  // Wait n clock edges, then move just after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One framed transfer of nbits, sclk stands still outside it
  task automatic frame(input int nbits);
    step(1);
    cs_n = 1'b0;
    step(6);
    for (int i = 0; i < nbits; i++) begin
      din = tx_buf[i / 8][7 - i % 8];
      step(4);
      sclk = 1'b1;
      step(3);
      // Read late in the high phase, well after the falling-edge update
      rx_buf[i / 8][7 - i % 8] = dout;
      step(1);
      sclk = 1'b0;
    end
    step(4);
    cs_n = 1'b1;
    din = ~din; // Released line shows the inverse of its last value
    step(10);
  endtask
endmodule

/* tb_monitor_adc_command_decoder.sv */
module tb_monitor_adc_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe, conv_start, alarm_clear;
  logic alarm_clear_all, shutdown;
  logic result_valid = 1'b0;
  logic [3:0] result_channel = 4'h0;
  logic [9:0] result_data = 10'h000;
  logic [23:0] alarm_status = 24'h000000;
  logic [3:0] conv_channel, alarm_clear_channel, last_conv, last_clr, ch;
  logic [11:0] channel_enable, input_pair_configuration, scan_enable;
  logic [11:0] en, cfg;
  logic [7:0] setup, st, cf;
  logic [9:0] v;
  logic [15:0] up, lo;
  logic [9:0] dat [0:9];
  logic [3:0] ma [0:5] = '{4'h2, 4'h3, 4'h5, 4'h0, 4'ha, 4'hf};
  logic mexp [0:5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [3:0] rc [0:2] = '{4'h6, 4'he, 4'hf};
  logic [31:0] seed = 32'h9217;
  int failures = 0;
  int num_checks = 0;
  int n_conv = 0;
  int n_clr = 0;
  int n_all = 0;
  int n_oe = 0;

  // Clock, 100 ns period
  always #50 clk = ~clk;

  monitor_adc_command_decoder u_monitor_adc_command_decoder (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe(dout_oe),
    .result_valid(result_valid), .result_channel(result_channel),
    .result_data(result_data), .conv_start(conv_start),
    .conv_channel(conv_channel), .alarm_status(alarm_status),
    .alarm_clear(alarm_clear), .alarm_clear_channel(alarm_clear_channel),
    .alarm_clear_all(alarm_clear_all), .channel_enable(channel_enable),
    .input_pair_configuration(input_pair_configuration),
    .setup(setup), .scan_enable(scan_enable), .shutdown(shutdown)
  );

  spi_host_model u_spi_host_model (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout)
  );

  // Pulse counters for conversion starts and alarm clears, and a count of cycles with the output enabled
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      n_conv++;
      last_conv = conv_channel;
    end
    if (alarm_clear === 1'b1) begin
      n_clr++;
      last_clr = alarm_clear_channel;
    end
    if (alarm_clear_all === 1'b1) n_all++;
    if (dout_oe === 1'b1) n_oe++;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Enable word with reserved bits and odd inputs of differential pairs off
  function automatic logic [11:0] exp_scan(input logic [11:0] e,
                                           input logic [11:0] c);
    logic [11:0] m;
    m = e & 12'hffc;
    for (int p = 0; p < 4; p++) if (c[11 - 3 * p]) m[8 - 2 * p] = 1'b0;
    return m;
  endfunction

  function automatic logic [15:0] rx16(input int k);
    return {u_spi_host_model.rx_buf[k], u_spi_host_model.rx_buf[k + 1]};
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Send up to six bytes in one frame of nbits
  task automatic send6(input logic [47:0] w, input int nbits);
    for (int i = 0; i < 6; i++) begin
      u_spi_host_model.tx_buf[i] = w[47 - 8 * i -: 8];
    end
    n_conv = 0;
    n_oe = 0;
    n_clr = 0;
    n_all = 0;
    u_spi_host_model.frame(nbits);
  endtask

  task automatic wr_global(input logic [11:0] e, input logic [11:0] c,
                           input logic [7:0] s);
    send6({8'hd0, 4'h0, e, 4'h0, c, s}, 48);
  endtask

  // Run limit
  initial begin
    for (int w = 0; w < 60000; w++) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    check(channel_enable, 12'hfff);
    check(input_pair_configuration, 12'h000);
    check(setup, 8'h00);
    check(shutdown, 1'b1);
    check(scan_enable, 12'hffc);
    // Global configuration, corners then random, written and read back
    for (int k = 0; k < 4; k++) begin
      en = (k == 0) ? 12'h000 : (k == 1) ? 12'hfff : 12'(rnd());
      cfg = (k == 1) ? 12'hfff : 12'(rnd());
      st = 8'(rnd()) & 8'hfb;
      wr_global(en, cfg, st);
      check(channel_enable, en);
      check(input_pair_configuration, cfg);
      check(setup, st);
      check(shutdown, 1'b0);
      check(scan_enable, exp_scan(en, cfg));
      send6({4'h5, 4'(rnd()), 40'h0}, 48);
      check({rx16(1), rx16(3), u_spi_host_model.rx_buf[5]},
            {4'h0, en, 4'h0, cfg, st});
      check(dout_oe, 1'b0);
      check(n_oe, 10 + 8 * 48);
    end
    // Manual conversion with all channels disabled, pair zero differential
    wr_global(12'h000, 12'h800, 8'h00);
    for (int k = 0; k < 6; k++) begin
      send6({4'h0, ma[k], 40'h0}, 8);
      check(n_conv, mexp[k]);
      if (mexp[k]) check(last_conv, ma[k]);
    end
    wr_global(12'hfff, 12'h000, 8'h04);
    send6({8'h02, 40'h0}, 8);
    check(n_conv, 0);
    // Selected data writes with corner channels, then read back
    for (int k = 0; k < 4; k++) begin
      ch = (k == 0) ? 4'h0 : (k == 1) ? 4'h9 : 4'(rnd() % 10);
      v = 10'(rnd());
      send6({4'ha, ch, v, 6'h0, 24'h0}, 24);
      send6({4'h2, ch, 40'h0}, 24);
      check(rx16(1), {v, 6'h00});
    end
    // Conversion result lands in the data register
    v = 10'(rnd());
    @(posedge clk);
    #1 result_valid = 1'b1;
    result_channel = 4'h4;
    result_data = v;
    @(posedge clk);
    #1 result_valid = 1'b0;
    // Result offered while the clock enable is low must be dropped
    @(posedge clk);
    #1 ce = 1'b0;
    result_valid = 1'b1;
    result_data = ~v;
    @(posedge clk);
    #1 ce = 1'b1;
    result_valid = 1'b0;
    // Aborted write leaves the data register alone
    send6({8'ha4, ~v, 6'h0, 24'h0}, 12);
    send6({8'h24, 40'h0}, 24);
    check(rx16(1), {v, 6'h00});
    // Write all data, read all and one selected
    u_spi_host_model.tx_buf[0] = {4'hb, 4'(rnd())};
    for (int i = 0; i < 10; i++) begin
      dat[i] = 10'(rnd());
      u_spi_host_model.tx_buf[1 + 2 * i] = dat[i][9:2];
      u_spi_host_model.tx_buf[2 + 2 * i] = {dat[i][1:0], 6'h00};
    end
    u_spi_host_model.frame(168);
    u_spi_host_model.tx_buf[0] = {4'h3, 4'(rnd())};
    u_spi_host_model.frame(168);
    for (int i = 0; i < 10; i++) begin
      check(rx16(1 + 2 * i), {dat[i], 6'h00});
    end
    send6({8'h29, 40'h0}, 24);
    check(rx16(1), {dat[9], 6'h00});
    // Channel configuration write and read back
    ch = 4'(rnd() % 10);
    up = {10'(rnd()), 6'h00};
    lo = {10'(rnd()), 6'h00};
    cf = 8'(rnd());
    send6({4'hc, ch, up, lo, cf}, 48);
    check(n_clr, 3);
    check(last_clr, ch);
    send6({4'h4, ch, 40'h0}, 48);
    check({rx16(1), rx16(3), u_spi_host_model.rx_buf[5]},
          {up, lo, cf});
    // Reserved channel address
    send6({8'hca, up, lo, cf}, 48);
    check(n_clr, 0);
    send6({8'h4a, 40'h0}, 48);
    check(rx16(1), 16'h0000);
    // Alarm readout with random address
    alarm_status = 24'(rnd());
    send6({4'h1, 4'(rnd()), 40'h0}, 32);
    check({rx16(1), u_spi_host_model.rx_buf[3]}, alarm_status);
    send6({4'h8, ch, 40'h0}, 8);
    check({n_clr[3:0], last_clr}, {4'h1, ch});
    send6({4'h9, 4'(rnd()), 40'h0}, 8);
    check(n_all, 1);
    // Reserved commands followed by data that looks like a global write
    for (int k = 0; k < 3; k++) begin
      send6({rc[k], 4'h0, 16'h0123, 16'h0456, 8'h00}, 48);
      check(n_clr + n_all + n_conv, 0);
      check({channel_enable, input_pair_configuration, setup},
            {12'hfff, 12'h000, 8'h04});
      check(rx16(1), 16'h0000);
    end
    // Reset command restores defaults
    wr_global(12'h5a4, 12'h249, 8'h24);
    send6({4'h7, 4'(rnd()), 40'h0}, 8);
    check({channel_enable, input_pair_configuration, setup},
          {12'hfff, 12'h000, 8'h00});
    check(shutdown, 1'b1);
    check(n_all, 1);
    tally_and_finish();
  end
endmodule
